// >>> common/sbw_pkg.sv
// Constants used by the block-write slave; the bus watcher uses none of them
package sbw_pkg;

  // ----------------------------------------
  // Packet framing values
  // ----------------------------------------
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'hbe;
  localparam logic [7:0] BYTE_COUNT_WR   = 8'h08;
  localparam logic [2:0] OP_WRITE        = 3'h3;
  localparam logic [2:0] OP_READ         = 3'h4;
  localparam logic [4:0] PORT_MAX        = 5'h02;

  // ----------------------------------------
  // Slave address
  // ----------------------------------------
  localparam logic [3:0] ADDR_FIXED_HI   = 4'hd;
  localparam logic [2:0] STRAP_RST       = 3'h0;

  // ----------------------------------------
  // Byte positions within a packet
  // ----------------------------------------
  localparam logic [3:0] IDX_ADDR        = 4'h0;
  localparam logic [3:0] IDX_CMD         = 4'h1;
  localparam logic [3:0] IDX_CNT         = 4'h2;
  localparam logic [3:0] IDX_CB1         = 4'h3;
  localparam logic [3:0] IDX_CB2         = 4'h4;
  localparam logic [3:0] IDX_CB3         = 4'h5;
  localparam logic [3:0] IDX_CB4         = 4'h6;
  localparam logic [3:0] IDX_DB1         = 4'h7;
  localparam logic [3:0] IDX_DB4         = 4'ha;
  localparam logic [3:0] IDX_PEC         = 4'hb;
  localparam logic [3:0] IDX_OVER        = 4'hc;

  // ----------------------------------------
  // Field positions in command byte 3
  // ----------------------------------------
  localparam int unsigned CB3_PORT_BIT   = 7;
  localparam int unsigned CB3_BE_MSB     = 5;
  localparam int unsigned CB3_BE_LSB     = 2;
  localparam int unsigned CB3_AHI_MSB    = 1;

  // ----------------------------------------
  // Error code and counters
  // ----------------------------------------
  localparam logic [7:0] CRC_POLY        = 8'h07;
  localparam logic [7:0] CRC_INIT        = 8'h00;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [1:0] STRAP_TAKE      = 2'h2;
  localparam logic [1:0] STRAP_DONE      = 2'h3;

endpackage

// >>> rtl/sbw_bus_watch.sv
// Synchroniser and condition detector for the two bus wires
`timescale 1ns/1ps

module sbw_bus_watch (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise_out,
  output logic      scl_fall_out,
  output logic      sda_out,
  output logic      start_out,
  output logic      stop_out
);

  // ----------------------------------------
  // Two-stage synchronisers plus history
  // ----------------------------------------
  logic scl_s1_ff;
  logic scl_s2_ff;
  logic scl_s3_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_s3_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
    end
  end

  // ----------------------------------------
  // Edges and bus conditions
  // ----------------------------------------
  // Data moving while the clock stays high marks start or stop
  assign scl_rise_out = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall_out = ~scl_s2_ff & scl_s3_ff;
  assign sda_out      = sda_s2_ff;
  assign start_out    = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
  assign stop_out     = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;

endmodule

// >>> rtl/sbw_block_write_slave.sv
// Bus slave that decodes block-write packets into configuration writes
`timescale 1ns/1ps

// What this block does
// - Packet: address, code, count, four command, four data, optional error code, stop.
// - Only command code BEh is accepted as a register write.
// - Byte count must be 08h; the error code byte is not counted.
// - After an invalid byte, NACK it and every later byte of the packet.
// - A byte count other than 8 is NACKed with all following bytes.
// - Byte after fourth data byte is the error code, checked when enabled.
// - Error code mismatch drops the write and NACKs the error code byte.
// - The check-off control bit disables error code verification.
// - First command byte bits 2:0 select operation; 011b is write, 100b read (this block accepts only 011b and NACKs 100b).
// - Port select is second byte bits 3:0 above third byte bit 7.
// - Third byte bits 5:2 are byte enables, bit 2 for bits 7:0.
// - Dword address: 11:10 from third byte, 9:2 from fourth, 1:0 zero.
// - Data bytes arrive most significant first, first byte to bits 31:24.
// - Default address is 1101000b with write bit cleared.
// - Acknowledge drives data low; NACK leaves the line high.
// - Address bits 2:0 come from straps, bits 6:3 fixed at 1101.
// - Software may replace the whole seven-bit slave address.
module sbw_block_write_slave (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        smb_clk_in,
  output logic             smb_clk_out,
  output logic             smb_clk_oe_out,
  input  wire logic        smb_data_in,
  output logic             smb_data_out,
  output logic             smb_data_oe_out,
  input  wire logic [2:0]  strap_addr_in,
  input  wire logic        error_code_check_off_in,
  input  wire logic        sw_addr_valid_in,
  input  wire logic [6:0]  sw_addr_in,
  output logic             cfg_wr_out,
  output logic [4:0]       cfg_port_out,
  output logic [11:0]      cfg_addr_out,
  output logic [3:0]       cfg_be_out,
  output logic [31:0]      cfg_data_out
);

  typedef enum logic [2:0] {
    SBW_IDLE,
    SBW_BITS,
    SBW_ACK_WAIT,
    SBW_ACK,
    SBW_SKIP
  } sbw_state_e;

  // ----------------------------------------
  // Error code step, polynomial x8+x2+x+1
  // ----------------------------------------
  function automatic logic [7:0] sbw_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ sbw_pkg::CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic        scl_rise;
  logic        scl_fall;
  logic        sda_s;
  logic        start_p;
  logic        stop_p;
  sbw_state_e  state_ff;
  sbw_state_e  nxt_state;
  logic [2:0]  bit_cnt_ff;
  logic [6:0]  shift_ff;
  logic [3:0]  idx_ff;
  logic        bad_ff;
  logic        ack_ok_ff;
  logic        oe_ff;
  logic [7:0]  crc_ff;
  logic [3:0]  port_hi_ff;
  logic        port_lo_ff;
  logic [3:0]  be_ff;
  logic [9:0]  addr_ff;
  logic [31:0] data_ff;
  logic [2:0]  strap_s1_ff;
  logic [2:0]  strap_s2_ff;
  logic [2:0]  strap_ff;
  logic [1:0]  strap_cnt_ff;
  logic        wr_ff;
  logic [4:0]  port_out_ff;
  logic [11:0] addr_out_ff;
  logic [3:0]  be_out_ff;
  logic [31:0] data_out_ff;

  // ----------------------------------------
  // Wire watcher
  // ----------------------------------------
  sbw_bus_watch u_watch (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .scl_in       (smb_clk_in),
    .sda_in       (smb_data_in),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .sda_out      (sda_s),
    .start_out    (start_p),
    .stop_out     (stop_p)
  );

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  // Straps are pins, so synchronise before the one-time capture
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_s1_ff  <= sbw_pkg::STRAP_RST;
      strap_s2_ff  <= sbw_pkg::STRAP_RST;
      strap_ff     <= sbw_pkg::STRAP_RST;
      strap_cnt_ff <= 2'h0;
    end else begin
      strap_s1_ff <= strap_addr_in;
      strap_s2_ff <= strap_s1_ff;
      if (strap_cnt_ff == sbw_pkg::STRAP_TAKE) begin
        strap_ff <= strap_s2_ff;
      end
      if (strap_cnt_ff != sbw_pkg::STRAP_DONE) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Byte decode
  // ----------------------------------------
  // Checks applied to the byte completing on this clock rise
  wire [7:0] rx_byte   = {shift_ff, sda_s};
  wire       byte_done = (state_ff == SBW_BITS) && scl_rise && (bit_cnt_ff == sbw_pkg::BIT_LAST);
  wire [6:0] own_addr  = sw_addr_valid_in ? sw_addr_in : {sbw_pkg::ADDR_FIXED_HI, strap_ff};
  wire       ok_addr   = (rx_byte[7:1] == own_addr) && !rx_byte[0];
  wire       ok_cmd    = rx_byte == sbw_pkg::CMD_BLOCK_WRITE;
  wire       ok_cnt    = rx_byte == sbw_pkg::BYTE_COUNT_WR;
  wire       ok_op     = rx_byte[2:0] == sbw_pkg::OP_WRITE;
  wire [4:0] port_sel  = {port_hi_ff, rx_byte[sbw_pkg::CB3_PORT_BIT]};
  wire       ok_port   = port_sel <= sbw_pkg::PORT_MAX;
  wire       ok_pec    = error_code_check_off_in || (rx_byte == crc_ff);
  wire       in_pkt    = (state_ff != SBW_IDLE) && (state_ff != SBW_SKIP);
  wire       byte_ok   = (idx_ff == sbw_pkg::IDX_CMD) ? ok_cmd :
                         (idx_ff == sbw_pkg::IDX_CNT) ? ok_cnt :
                         (idx_ff == sbw_pkg::IDX_CB1) ? ok_op :
                         (idx_ff == sbw_pkg::IDX_CB3) ? ok_port :
                         (idx_ff == sbw_pkg::IDX_PEC) ? ok_pec :
                         (idx_ff != sbw_pkg::IDX_OVER);
  wire       commit    = stop_p && in_pkt && !bad_ff && (idx_ff >= sbw_pkg::IDX_PEC);

  // ----------------------------------------
  // Packet sequencer
  // ----------------------------------------
  // Start and stop override every state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SBW_IDLE: begin
        nxt_state = SBW_IDLE;
      end
      SBW_BITS: begin
        if (byte_done) begin
          nxt_state = (idx_ff == sbw_pkg::IDX_ADDR && !ok_addr) ? SBW_SKIP : SBW_ACK_WAIT;
        end
      end
      SBW_ACK_WAIT: begin
        if (scl_fall) begin
          nxt_state = SBW_ACK;
        end
      end
      SBW_ACK: begin
        if (scl_fall) begin
          nxt_state = SBW_BITS;
        end
      end
      SBW_SKIP: begin
        nxt_state = SBW_SKIP;
      end
    endcase
    if (start_p) begin
      nxt_state = SBW_BITS;
    end else if (stop_p) begin
      nxt_state = SBW_IDLE;
    end
  end

  // State and bit counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff   <= SBW_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff   <= 7'h00;
    end else begin
      state_ff <= nxt_state;
      if (start_p || (state_ff == SBW_ACK && scl_fall)) begin
        bit_cnt_ff <= 3'h0;
      end else if (state_ff == SBW_BITS && scl_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shift_ff   <= rx_byte[6:0];
      end
    end
  end

  // Byte index, sticky error and running error code
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_ff    <= 4'h0;
      bad_ff    <= 1'b0;
      ack_ok_ff <= 1'b0;
      crc_ff    <= sbw_pkg::CRC_INIT;
    end else if (start_p) begin
      idx_ff <= 4'h0;
      bad_ff <= 1'b0;
      crc_ff <= sbw_pkg::CRC_INIT;
    end else if (byte_done) begin
      ack_ok_ff <= byte_ok && !bad_ff;
      bad_ff    <= bad_ff || !byte_ok;
      crc_ff    <= sbw_crc8(crc_ff, rx_byte);
      if (idx_ff != sbw_pkg::IDX_OVER) begin
        idx_ff <= idx_ff + 4'h1;
      end
    end
  end

  // Field capture from command and data bytes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_hi_ff <= 4'h0;
      port_lo_ff <= 1'b0;
      be_ff      <= 4'h0;
      addr_ff    <= 10'h000;
      data_ff    <= 32'h0000_0000;
    end else if (byte_done) begin
      if (idx_ff == sbw_pkg::IDX_CB2) begin
        port_hi_ff <= rx_byte[3:0];
      end
      if (idx_ff == sbw_pkg::IDX_CB3) begin
        port_lo_ff     <= rx_byte[sbw_pkg::CB3_PORT_BIT];
        be_ff          <= rx_byte[sbw_pkg::CB3_BE_MSB:sbw_pkg::CB3_BE_LSB];
        addr_ff[9:8]   <= rx_byte[sbw_pkg::CB3_AHI_MSB:0];
      end
      if (idx_ff == sbw_pkg::IDX_CB4) begin
        addr_ff[7:0] <= rx_byte;
      end
      if (idx_ff >= sbw_pkg::IDX_DB1 && idx_ff <= sbw_pkg::IDX_DB4) begin
        data_ff <= {data_ff[23:0], rx_byte};
      end
    end
  end

  // ----------------------------------------
  // Acknowledge driver
  // ----------------------------------------
  // Pull low through the ack clock only for accepted bytes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_ff <= 1'b0;
    end else if (start_p || stop_p) begin
      oe_ff <= 1'b0;
    end else if (state_ff == SBW_ACK_WAIT && scl_fall) begin
      oe_ff <= ack_ok_ff;
    end else if (state_ff == SBW_ACK && scl_fall) begin
      oe_ff <= 1'b0;
    end
  end

  assign smb_data_out    = 1'b0;
  assign smb_data_oe_out = oe_ff;
  assign smb_clk_out     = 1'b0;
  assign smb_clk_oe_out  = 1'b0;

  // ----------------------------------------
  // Configuration write port
  // ----------------------------------------
  // One-cycle strobe at the stop of a clean packet
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ff       <= 1'b0;
      port_out_ff <= 5'h00;
      addr_out_ff <= 12'h000;
      be_out_ff   <= 4'h0;
      data_out_ff <= 32'h0000_0000;
    end else begin
      wr_ff <= commit;
      if (commit) begin
        port_out_ff <= {port_hi_ff, port_lo_ff};
        addr_out_ff <= {addr_ff, 2'b00};
        be_out_ff   <= be_ff;
        data_out_ff <= data_ff;
      end
    end
  end

  assign cfg_wr_out   = wr_ff;
  assign cfg_port_out = port_out_ff;
  assign cfg_addr_out = addr_out_ff;
  assign cfg_be_out   = be_out_ff;
  assign cfg_data_out = data_out_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_ack_on_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(smb_data_oe_out) |-> $past(state_ff) == SBW_ACK_WAIT && $past(scl_fall) && $past(ack_ok_ff))
    else $error("ack drive not tied to an accepted byte");

  chk_bad_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bad_ff && !start_p) |=> bad_ff)
    else $error("error flag dropped inside a packet");

  chk_nack_after_bad: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_ff == SBW_ACK && bad_ff) |-> !smb_data_oe_out)
    else $error("byte acknowledged after an invalid byte");

  chk_count_nack: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (byte_done && idx_ff == sbw_pkg::IDX_CNT && rx_byte != 8'h08) |=> bad_ff && !ack_ok_ff)
    else $error("wrong byte count accepted");

  chk_cmd_nack: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (byte_done && idx_ff == sbw_pkg::IDX_CMD && rx_byte != 8'hbe) |=> bad_ff)
    else $error("wrong command code accepted");

  chk_pec_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (byte_done && idx_ff == sbw_pkg::IDX_PEC && !error_code_check_off_in && rx_byte != crc_ff)
      |=> !ack_ok_ff ##0 (!cfg_wr_out)[*2])
    else $error("bad error code not dropped");

  chk_pec_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (byte_done && idx_ff == sbw_pkg::IDX_PEC && error_code_check_off_in && !bad_ff) |=> ack_ok_ff)
    else $error("error code checked while disabled");

  chk_commit_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_wr_out |-> $past(stop_p) && !$past(bad_ff) && $past(idx_ff) >= sbw_pkg::IDX_PEC)
    else $error("write committed without a clean stop");

  chk_port_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cfg_wr_out |-> cfg_port_out <= 5'h02 && cfg_addr_out[1:0] == 2'b00)
    else $error("committed port or address out of range");

endmodule

// >>> verification/sbw_master_model.sv
// Behavioural bus master that frames packets and samples acknowledges
`timescale 1ns/1ps

module sbw_master_model (
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  // Idle: both lines released to the pull-up level
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Start: data falls while the clock is high; offset keeps edges off the core clock
  task automatic bus_start();
    #13;
    sda_out = 1'b1;
    scl_out = 1'b1;
    #160 sda_out = 1'b0;
    #160 scl_out = 1'b0;
  endtask

  // Byte most significant bit first, then release data and sample the answer
  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      #100 sda_out = b[i];
      #60 scl_out = 1'b1;
      #160 scl_out = 1'b0;
    end
    #100 sda_out = 1'b1;
    #60 scl_out = 1'b1;
    #80 ack_n = sda_in;
    #80 scl_out = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the clock stands high
  task automatic bus_stop();
    #100 sda_out = 1'b0;
    #60 scl_out = 1'b1;
    #160 sda_out = 1'b1;
    #160;
  endtask
endmodule

// >>> verification/sbw_block_write_slave_tb.sv
// Self-checking bench for the block-write slave
`timescale 1ns/1ps

module sbw_block_write_slave_tb;
  localparam int LIMIT = 30000;
  logic        clk_in;
  logic        rst_n_in;
  logic        scl_rel;
  logic        sda_rel;
  logic        clk_o;
  logic        clk_oe;
  logic        dat_o;
  logic        dat_oe;
  logic [2:0]  strap;
  logic        chk_off;
  logic        sw_vld;
  logic [6:0]  sw_addr;
  logic        cfg_wr;
  logic [4:0]  cfg_port;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_data;
  logic [7:0]  pk [$];
  int          fail_count;
  int          n_checks;
  int          n_wr;
  int          cyc;
  wire         scl_wire;
  wire         sda_wire;

  // Open-drain wires: low while any party pulls
  assign scl_wire = scl_rel & ~(clk_oe & ~clk_o);
  assign sda_wire = sda_rel & ~(dat_oe & ~dat_o);

  sbw_master_model mst (
    .scl_out (scl_rel),
    .sda_out (sda_rel),
    .sda_in  (sda_wire)
  );

  sbw_block_write_slave dut (
    .clk_in                  (clk_in),
    .rst_n_in                (rst_n_in),
    .smb_clk_in              (scl_wire),
    .smb_clk_out             (clk_o),
    .smb_clk_oe_out          (clk_oe),
    .smb_data_in             (sda_wire),
    .smb_data_out            (dat_o),
    .smb_data_oe_out         (dat_oe),
    .strap_addr_in           (strap),
    .error_code_check_off_in (chk_off),
    .sw_addr_valid_in        (sw_vld),
    .sw_addr_in              (sw_addr),
    .cfg_wr_out              (cfg_wr),
    .cfg_port_out            (cfg_port),
    .cfg_addr_out            (cfg_addr),
    .cfg_be_out              (cfg_be),
    .cfg_data_out            (cfg_data)
  );

  // Core clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Commit counter and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cfg_wr === 1'b1) n_wr <= n_wr + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end

  // Count a comparison, report a mismatch
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // Counts and verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Error code: polynomial 07h, start 00h, bytes in bus order
  function automatic logic [7:0] crc8(input logic [7:0] q [$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) begin
      c = c ^ q[i];
      repeat (8) c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Packet with default address, write code and count
  task automatic pkt(input logic [7:0] c1, c2, c3, c4, input logic [31:0] d);
    pk = {8'hd0, 8'hbe, 8'h08, c1, c2, c3, c4, d[31:24], d[23:16], d[15:8], d[7:0]};
  endtask

  // Send pk, judge each acknowledge, then judge the commit
  task automatic run(input int n_ack, input logic wr, input logic [4:0] p = 5'h00,
                     input logic [11:0] a = 12'h000, input logic [3:0] e = 4'h0, input logic [31:0] d = 32'h0);
    logic ack_n;
    int   n0;
    n0 = n_wr;
    mst.bus_start();
    foreach (pk[i]) begin
      mst.put_byte(pk[i], ack_n);
      check(ack_n === 1'(i >= n_ack), $sformatf("byte %0d answer", i));
    end
    mst.bus_stop();
    repeat (8) @(posedge clk_in);
    check(n_wr === n0 + int'(wr), "commit count");
    if (wr) check({cfg_port, cfg_addr, cfg_be, cfg_data} === {p, a, e, d}, "commit fields");
    check({dat_o, clk_oe, dat_oe} === 3'b000, "lines not released after stop");
  endtask

  // Sample write to port 1, offset F8h, no error code
  task automatic t_sample();
    pkt(8'h03, 8'h00, 8'hbc, 8'h3e, 32'h1234_5678);
    run(11, 1'b1, 5'h01, 12'h0f8, 4'hf, 32'h1234_5678);
    $display("t_sample done");
  endtask

  // Error code good, bad, and bad with checking off; reserved bits set
  task automatic t_pec();
    pkt(8'hfb, 8'h01, 8'h57, 8'ha5, 32'hdead_beef);
    pk.push_back(crc8(pk));
    run(12, 1'b1, 5'h02, 12'he94, 4'h5, 32'hdead_beef);
    pkt(8'h03, 8'h01, 8'h57, 8'ha5, 32'h0bad_f00d);
    pk.push_back(crc8(pk) ^ 8'h01);
    run(11, 1'b0);
    @(posedge clk_in);
    chk_off <= 1'b1;
    run(12, 1'b1, 5'h02, 12'he94, 4'h5, 32'h0bad_f00d);
    @(posedge clk_in);
    chk_off <= 1'b0;
    $display("t_pec done");
  endtask

  // Invalid address, command code, byte count, operation and port select
  task automatic t_errors();
    pkt(8'h03, 8'h00, 8'hbc, 8'h3e, 32'h1111_2222);
    pk[1] = 8'hba;
    run(1, 1'b0);
    pk[1] = 8'hbe;
    pk[2] = 8'h04;
    run(2, 1'b0);
    pk[2] = 8'h08;
    pk[3] = 8'h04;
    run(3, 1'b0);
    pk[3] = 8'h03;
    pk[4] = 8'h01;
    run(5, 1'b0);
    pk[4] = 8'h00;
    pk[0] = 8'hd2;
    run(0, 1'b0);
    pk[0] = 8'hd1;
    run(0, 1'b0);
    $display("t_errors done");
  endtask

  // Strap address after a second reset, then software address
  task automatic t_addr();
    @(posedge clk_in);
    strap <= 3'h5;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    pkt(8'h03, 8'h00, 8'h3c, 8'h01, 32'hcafe_0001);
    run(0, 1'b0);
    pk[0] = 8'hda;
    run(11, 1'b1, 5'h00, 12'h004, 4'hf, 32'hcafe_0001);
    @(posedge clk_in);
    sw_vld <= 1'b1;
    sw_addr <= 7'h22;
    run(0, 1'b0);
    pk[0] = 8'h44;
    run(11, 1'b1, 5'h00, 12'h004, 4'hf, 32'hcafe_0001);
    @(posedge clk_in);
    sw_vld <= 1'b0;
    $display("t_addr done");
  endtask

  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    strap = 3'h0;
    chk_off = 1'b0;
    sw_vld = 1'b0;
    sw_addr = 7'h00;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    t_sample();
    t_pec();
    t_errors();
    t_addr();
    tally_and_finish();
  end
endmodule
